// >>> rtl/perf_monitor_regs.svh
// register indices, field positions and timing constants of the performance monitor
// Notes on behaviour
// - all holding registers load together from their live counters at one instant.
// - a zero-to-one change of the manual update bit loads every holding register.
// - while auto update is one, the holding group reloads once every second.
// - ten-bit crc-6 error count in extended superframe; low byte 00, top bits 01.
// - twelve-bit framing error count; low byte at 02, top four bits at 03.
// - three-bit count at 04 of framing bit position changes.
// - five-bit count at 05 of losses of synchronization in any frame format.
// - sixteen-bit pattern detector bit error count; low byte 06, high byte 07.
// - sixteen-bit line code violation count; low byte 08, high byte 09.
// - ten-bit data pattern error count in digital data mode; low byte 0a.
// - top two data pattern error bits sit in bits 1:0 at 0b.
`ifndef PERF_MONITOR_REGS_SVH
`define PERF_MONITOR_REGS_SVH

// -----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// -----------------------------------------------------------------------------
`define IDX_CRC6_LOW          6'h00
`define IDX_CRC6_HIGH         6'h01
`define IDX_FRAMING_LOW       6'h02
`define IDX_FRAMING_HIGH      6'h03
`define IDX_POSITION_CHANGE   6'h04
`define IDX_SYNC_LOSS         6'h05
`define IDX_PATTERN_LOW       6'h06
`define IDX_PATTERN_HIGH      6'h07
`define IDX_LINE_CODE_LOW     6'h08
`define IDX_LINE_CODE_HIGH    6'h09
`define IDX_DATA_PATTERN_LOW  6'h0a
`define IDX_DATA_PATTERN_HIGH 6'h0b
`define IDX_UPDATE_CONTROL    6'h0c
`define IDX_UPDATE_STATUS     6'h0d
`define IDX_LAST              6'h0d

// -----------------------------------------------------------------------------
// counter widths and fields
// -----------------------------------------------------------------------------
`define CRC6_WIDTH            10
`define FRAMING_WIDTH         12
`define POSITION_WIDTH        3
`define SYNC_LOSS_WIDTH       5
`define PATTERN_WIDTH         16
`define LINE_CODE_WIDTH       16
`define DATA_PATTERN_WIDTH    10
`define CTRL_AUTO_BIT         0
`define CTRL_MANUAL_BIT       1
`define CTRL_RESET            2'h0
`define COUNT_RESET           8'h00

// -----------------------------------------------------------------------------
// bus answers
// -----------------------------------------------------------------------------
`define RESP_OKAY             2'h0
`define RESP_SLVERR           2'h2

// -----------------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------------
`define CLK_PERIOD_PS         4000
`define UPDATE_INTERVAL_MS    1000
`define UPDATE_INTERVAL_CYCLES ((`UPDATE_INTERVAL_MS * 64'd1000000000) / `CLK_PERIOD_PS)

`endif

// >>> rtl/perf_monitor_pkg.sv
// types shared by the performance monitor files
`default_nettype none

package perf_monitor_pkg;

  typedef enum logic [1:0] {
    fmt_superframe          = 2'b00,
    fmt_extended_superframe = 2'b01,
    fmt_digital_data_mode   = 2'b10,
    fmt_subscriber_loop     = 2'b11
  } frame_format_t;

  typedef logic [5:0] reg_index_t;

endpackage

`default_nettype wire

// >>> rtl/event_counter.sv
// live event counter with a holding copy taken on each group update
`default_nettype none

module event_counter #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // events
  input  wire logic             event_pulse,
  input  wire logic             count_enable,
  input  wire logic             snapshot,
  // held value
  output logic [WIDTH-1:0]      held
);

  logic [WIDTH-1:0] live;
  logic             increment;

  assign increment = event_pulse & count_enable;

  // saturate rather than wrap: a wrapped count reads as fewer errors than seen
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      live <= '0;
    end else if (snapshot) begin
      live <= {{(WIDTH-1){1'b0}}, increment};
    end else if (increment && (live != {WIDTH{1'b1}})) begin
      live <= live + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      held <= '0;
    end else if (snapshot) begin
      held <= live;
    end
  end

endmodule // event_counter

`default_nettype wire

// >>> rtl/second_tick.sv
// interval timer giving one pulse per update period while enabled
`default_nettype none

module second_tick #(
  parameter longint unsigned PERIOD = 64'd250000000
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // control
  input  wire logic enable,
  // one-cycle pulse
  output logic      tick
);

  localparam int unsigned CW = $clog2(PERIOD + 64'd1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 64'd1);

  logic [CW-1:0] count;

  // the interval restarts whenever auto update is switched on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (!enable) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (count == LAST) begin
      count <= '0;
      tick  <= 1'b1;
    end else begin
      count <= count + {{(CW-1){1'b0}}, 1'b1};
      tick  <= 1'b0;
    end
  end

endmodule // second_tick

`default_nettype wire

// >>> rtl/performance_monitor.sv
// performance monitor counter bank with axi4-lite register access
`include "perf_monitor_regs.svh"
`default_nettype none

module performance_monitor #(
  parameter int unsigned     ADDR_WIDTH             = 8,
  parameter longint unsigned UPDATE_INTERVAL_CYCLES = `UPDATE_INTERVAL_CYCLES
) (
  // clock and reset
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  // write address channel
  input  wire logic [ADDR_WIDTH-1:0]          s_axi_awaddr,
  input  wire logic [2:0]                     s_axi_awprot,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  // write data channel
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  // write response channel
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  // read address channel
  input  wire logic [ADDR_WIDTH-1:0]          s_axi_araddr,
  input  wire logic [2:0]                     s_axi_arprot,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  // read data channel
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  // receive framer state and events, same clock
  input  wire perf_monitor_pkg::frame_format_t frame_format,
  input  wire logic                           crc6_error_event,
  input  wire logic                           framing_error_event,
  input  wire logic                           frame_position_change_event,
  input  wire logic                           sync_loss_event,
  input  wire logic                           pattern_bit_error_event,
  input  wire logic                           line_code_violation_event,
  input  wire logic                           data_pattern_error_event
);

  import perf_monitor_pkg::*;

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic reg_index_t index_of(input logic [ADDR_WIDTH-1:0] addr);
    index_of = addr[7:2];
  endfunction

  // shifting rather than slicing keeps the check legal when ADDR_WIDTH is exactly 8
  function automatic logic is_mapped(input logic [ADDR_WIDTH-1:0] addr);
    is_mapped = (addr[1:0] == 2'h0) && (index_of(addr) <= `IDX_LAST) &&
                ((addr >> 8) == '0);
  endfunction

  // ---------------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------------
  logic [ADDR_WIDTH-1:0]          write_addr;
  logic [31:0]                    write_data;
  logic [3:0]                     write_strb;
  logic                           write_addr_held;
  logic                           write_data_held;
  logic                           do_write;
  logic                           auto_update_enable;
  logic                           manual_update_trigger;
  logic                           manual_update_prev;
  logic                           manual_rise;
  logic                           auto_tick;
  logic                           group_update;
  logic [7:0]                     update_count;
  logic [31:0]                    next_rdata;
  logic [1:0]                     next_rresp;
  logic [`CRC6_WIDTH-1:0]         crc6_error_count;
  logic [`FRAMING_WIDTH-1:0]      framing_error_count;
  logic [`POSITION_WIDTH-1:0]     frame_position_change_count;
  logic [`SYNC_LOSS_WIDTH-1:0]    sync_loss_count;
  logic [`PATTERN_WIDTH-1:0]      pattern_bit_error_count;
  logic [`LINE_CODE_WIDTH-1:0]    line_code_violation_count;
  logic [`DATA_PATTERN_WIDTH-1:0] data_pattern_error_count;
  logic                           esf_active;
  logic                           data_mode_active;

  // a literal cannot be bit-selected, so the reset pattern gets a name first
  localparam logic [1:0]          CTRL_RESET_VALUE = `CTRL_RESET;

  // ---------------------------------------------------------------------------
  // write address and data, taken in either order
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready   <= 1'b0;
      write_addr_held <= 1'b0;
      write_addr      <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready   <= 1'b0;
      write_addr_held <= 1'b1;
      write_addr      <= s_axi_awaddr;
    end else if (do_write) begin
      write_addr_held <= 1'b0;
    end else if (!write_addr_held && !s_axi_bvalid) begin
      s_axi_awready   <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready    <= 1'b0;
      write_data_held <= 1'b0;
      write_data      <= '0;
      write_strb      <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready    <= 1'b0;
      write_data_held <= 1'b1;
      write_data      <= s_axi_wdata;
      write_strb      <= s_axi_wstrb;
    end else if (do_write) begin
      write_data_held <= 1'b0;
    end else if (!write_data_held && !s_axi_bvalid) begin
      s_axi_wready    <= 1'b1;
    end
  end

  assign do_write = write_addr_held && write_data_held && !s_axi_bvalid;

  // ---------------------------------------------------------------------------
  // write response
  // ---------------------------------------------------------------------------
  // counter registers are read only; writing them is accepted and ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= is_mapped(write_addr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // update control register
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      auto_update_enable    <= CTRL_RESET_VALUE[`CTRL_AUTO_BIT];
      manual_update_trigger <= CTRL_RESET_VALUE[`CTRL_MANUAL_BIT];
    end else if (do_write && is_mapped(write_addr) && write_strb[0] &&
                 (index_of(write_addr) == `IDX_UPDATE_CONTROL)) begin
      auto_update_enable    <= write_data[`CTRL_AUTO_BIT];
      manual_update_trigger <= write_data[`CTRL_MANUAL_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      manual_update_prev <= CTRL_RESET_VALUE[`CTRL_MANUAL_BIT];
    end else begin
      manual_update_prev <= manual_update_trigger;
    end
  end

  // only the rising edge counts, so software must write zero before each request
  assign manual_rise = manual_update_trigger && !manual_update_prev;

  second_tick #(
    .PERIOD (UPDATE_INTERVAL_CYCLES)
  ) interval_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .enable  (auto_update_enable),
    .tick    (auto_tick)
  );

  // one strobe feeds every counter so the whole group shares one instant
  assign group_update = manual_rise | auto_tick;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      update_count <= `COUNT_RESET;
    end else if (group_update) begin
      update_count <= update_count + 8'h01;
    end
  end

  // ---------------------------------------------------------------------------
  // live counters and holding registers
  // ---------------------------------------------------------------------------
  assign esf_active       = (frame_format == fmt_extended_superframe);
  assign data_mode_active = (frame_format == fmt_digital_data_mode);

  event_counter #(
    .WIDTH (`CRC6_WIDTH)
  ) crc6_counter (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .event_pulse  (crc6_error_event),
    .count_enable (esf_active),
    .snapshot     (group_update),
    .held         (crc6_error_count)
  );

  // f-bit errors in sf, data mode and subscriber loop; alignment errors in esf
  event_counter #(
    .WIDTH (`FRAMING_WIDTH)
  ) framing_counter (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .event_pulse  (framing_error_event),
    .count_enable (1'b1),
    .snapshot     (group_update),
    .held         (framing_error_count)
  );

  event_counter #(
    .WIDTH (`POSITION_WIDTH)
  ) position_counter (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .event_pulse  (frame_position_change_event),
    .count_enable (1'b1),
    .snapshot     (group_update),
    .held         (frame_position_change_count)
  );

  event_counter #(
    .WIDTH (`SYNC_LOSS_WIDTH)
  ) sync_loss_counter (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .event_pulse  (sync_loss_event),
    .count_enable (1'b1),
    .snapshot     (group_update),
    .held         (sync_loss_count)
  );

  event_counter #(
    .WIDTH (`PATTERN_WIDTH)
  ) pattern_counter (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .event_pulse  (pattern_bit_error_event),
    .count_enable (1'b1),
    .snapshot     (group_update),
    .held         (pattern_bit_error_count)
  );

  event_counter #(
    .WIDTH (`LINE_CODE_WIDTH)
  ) line_code_counter (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .event_pulse  (line_code_violation_event),
    .count_enable (1'b1),
    .snapshot     (group_update),
    .held         (line_code_violation_count)
  );

  event_counter #(
    .WIDTH (`DATA_PATTERN_WIDTH)
  ) data_pattern_counter (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .event_pulse  (data_pattern_error_event),
    .count_enable (data_mode_active),
    .snapshot     (group_update),
    .held         (data_pattern_error_count)
  );

  // ---------------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = `RESP_OKAY;
    if (!is_mapped(s_axi_araddr)) begin
      next_rresp = `RESP_SLVERR;
    end else begin
      unique case (index_of(s_axi_araddr))
        `IDX_CRC6_LOW: begin
          next_rdata[7:0] = crc6_error_count[7:0];
        end
        `IDX_CRC6_HIGH: begin
          next_rdata[1:0] = crc6_error_count[9:8];
        end
        `IDX_FRAMING_LOW: begin
          next_rdata[7:0] = framing_error_count[7:0];
        end
        `IDX_FRAMING_HIGH: begin
          next_rdata[3:0] = framing_error_count[11:8];
        end
        `IDX_POSITION_CHANGE: begin
          next_rdata[2:0] = frame_position_change_count;
        end
        `IDX_SYNC_LOSS: begin
          next_rdata[4:0] = sync_loss_count;
        end
        `IDX_PATTERN_LOW: begin
          next_rdata[7:0] = pattern_bit_error_count[7:0];
        end
        `IDX_PATTERN_HIGH: begin
          next_rdata[7:0] = pattern_bit_error_count[15:8];
        end
        `IDX_LINE_CODE_LOW: begin
          next_rdata[7:0] = line_code_violation_count[7:0];
        end
        `IDX_LINE_CODE_HIGH: begin
          next_rdata[7:0] = line_code_violation_count[15:8];
        end
        `IDX_DATA_PATTERN_LOW: begin
          next_rdata[7:0] = data_pattern_error_count[7:0];
        end
        `IDX_DATA_PATTERN_HIGH: begin
          next_rdata[1:0] = data_pattern_error_count[9:8];
        end
        `IDX_UPDATE_CONTROL: begin
          next_rdata[`CTRL_AUTO_BIT]   = auto_update_enable;
          next_rdata[`CTRL_MANUAL_BIT] = manual_update_trigger;
        end
        `IDX_UPDATE_STATUS: begin
          next_rdata[7:0] = update_count;
        end
        default: begin
          next_rresp = `RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // holding values only change on group_update, so a read never sees a half update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // performance_monitor

`default_nettype wire

// >>> verification/perf_monitor_properties.sv
// concurrent checks on the performance monitor bus ports
`default_nettype none

module perf_monitor_checker (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // write channels
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // read channels
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ---------------------------------------------------------------------------
  // handshake steps
  // ---------------------------------------------------------------------------
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_reopens;
    !s_axi_arready ##1 s_axi_arready;
  endsequence
  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  a_write_answer: assert property (both_taken |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data changed while waiting");
  a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open during data");
  a_read_reopens: assert property (s_axi_rvalid && s_axi_rready |=> ar_reopens)
    else $error("read address did not reopen");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_error_empty: assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("bad error read");
endmodule // perf_monitor_checker

bind performance_monitor perf_monitor_checker u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

`default_nettype wire

// >>> verification/testbench.sv
// self-checking bench for the performance monitor counter bank
`include "perf_monitor_regs.svh"
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import perf_monitor_pkg::*;
  localparam int         N    = 20;
  localparam logic [7:0] CTRL = {`IDX_UPDATE_CONTROL, 2'b00};
  logic          aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]    awaddr = 8'h0, araddr = 8'h0;
  logic [31:0]   wdata = 32'h0, rdata;
  logic [3:0]    wstrb = 4'h0;
  logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic          awready, wready, bvalid, arready, rvalid;
  logic [1:0]    bresp, rresp, ctrl_m = 2'h0;
  frame_format_t fmt = fmt_superframe;
  logic [6:0]    ev = 7'h0;
  logic          ev_on = 1'b0, arm = 1'b0;
  logic [31:0]   rnd = 32'hf0fe0029;
  int            live[7], held[7], maxv[7] = '{1023, 4095, 7, 31, 65535, 65535, 1023};
  int            upd_cnt, err_total, checks, cyc, i, r;

  always #2 aclk = ~aclk;

  performance_monitor #(.ADDR_WIDTH(8), .UPDATE_INTERVAL_CYCLES(N)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .frame_format(fmt), .crc6_error_event(ev[0]),
    .framing_error_event(ev[1]), .frame_position_change_event(ev[2]), .sync_loss_event(ev[3]),
    .pattern_bit_error_event(ev[4]), .line_code_violation_event(ev[5]),
    .data_pattern_error_event(ev[6])
  );

  // ---------------------------------------------------------------------------
  // stimulus and reference model
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  always @(posedge aclk) begin
    rnd <= lfsr(rnd);
    ev  <= ev_on ? rnd[6:0] : 7'h0;
  end

  // update taken at the write response edge; same-cycle events land in the new interval
  always @(posedge aclk) begin
    if (!aresetn) begin
      upd_cnt = 0;
      live    = '{default: 0};
      held    = '{default: 0};
    end else begin
      if (arm && bvalid && bready) begin
        arm     = 1'b0;
        upd_cnt = (upd_cnt + 1) % 256;
        held    = live;
        live    = '{default: 0};
      end
      foreach (live[k]) begin
        if (ev[k] && live[k] < maxv[k] && (k == 0 ? fmt == fmt_extended_superframe :
            k == 6 ? fmt == fmt_digital_data_mode : 1'b1)) begin
          live[k]++;
        end
      end
    end
  end

  function automatic logic [31:0] expv(input int x);
    int c;
    c = x < 4 ? x / 2 : x < 6 ? x - 2 : x / 2 + 1;
    if (x == 12) return {30'h0, ctrl_m};
    if (x == 13) return upd_cnt;
    return (held[c] >> ((x < 4 || x > 5) ? 8 * (x % 2) : 0)) & 255;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    bit done;
    @(posedge aclk);
    if (a == CTRL && s[0]) begin
      arm    = d[1] && !ctrl_m[1];
      ctrl_m = d[1:0];
    end
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    done    = 1'b0;
    while (!done) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        done   = 1'b1;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    bit done;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    done    = 1'b0;
    while (!done) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        done   = 1'b1;
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        chk("rdata", er != 2'h0 ? 32'h0 : expv(a / 4), rdata);
      end
    end
  endtask

  task automatic read_all();
    for (i = 0; i < 14; i++) rd(8'(i * 4), 2'h0);
  endtask

  task automatic finish_test();
    if (err_total == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 10000) begin
      err_total++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    read_all();
    for (r = 0; r < 8; r++) begin
      fmt   <= frame_format_t'(r[1:0]);
      ev_on <= 1'b1;
      repeat (20 + rnd[4:0]) @(posedge aclk);
      wr(CTRL, 32'h0, 4'h1, 2'h0);
      wr(CTRL, 32'h2, 4'h1, 2'h0);
      if (r == 3) begin
        wr(CTRL, 32'h2, 4'h1, 2'h0);
        wr(CTRL, 32'h0, 4'h0, 2'h0);
        wr(8'h00, 32'hff, 4'hf, 2'h0);
        wr(8'h38, 32'h3, 4'hf, 2'h2);
      end
      read_all();
      rd(8'h38, 2'h2);
      rd(8'h05, 2'h2);
    end
    // events stop so the automatic updates end with an empty holding group
    ev_on <= 1'b0;
    wr(CTRL, 32'h1, 4'h1, 2'h0);
    repeat (5 * N + N / 2) @(posedge aclk);
    wr(CTRL, 32'h0, 4'h1, 2'h0);
    upd_cnt = (upd_cnt + 5) % 256;
    held    = '{default: 0};
    read_all();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    ctrl_m  = 2'h0;
    read_all();
    finish_test();
  end
endmodule // testbench

`default_nettype wire
